// ---- design/ppcs_pin_mux.sv ----
// module: strap-selected gpio / chip-select mux for three parallel-port pins
// Function
// - strap low gpio, strap high chip select
// - function fixed at reset release until reset
// - gpio pins are inputs after reset while gpio_dir_out_i is zero
// - chip select floats in reset, then drives 1
// - pins map to spaces zero, one, two
// - software picks gpio input or output
// - pins float while hold is asserted
// - memory clocks toggle or float during hold
// - pins float in off mode
// - bus holder enable, default on after reset
`timescale 1ns/1ps
`default_nettype none
module ppcs_pin_mux
   import ppcs_pkg::*;
#(
   parameter int NUM_PINS = PPCS_NUM_PINS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic function_strap_input_i,
   input wire logic [NUM_PINS-1:0] pin_i,
   output logic [NUM_PINS-1:0] pin_o,
   output logic [NUM_PINS-1:0] pin_oe_o,
   input wire logic [NUM_PINS-1:0] gpio_dir_out_i,
   input wire logic [NUM_PINS-1:0] gpio_out_i,
   output logic [NUM_PINS-1:0] gpio_in_o,
   input wire logic [NUM_PINS-1:0] mem_space_select_i,
   input wire logic hold_i,
   input wire logic memclk_i,
   input wire logic memclk_hold_tristate_bit_i,
   output logic memory_clock_outputs_o,
   output logic memory_clock_outputs_oe_o,
   input wire logic test_reset_i,
   input wire logic emulation_pin_zero_i,
   input wire logic emulation_one_off_input_i,
   input wire logic holder_enable_wr_i,
   input wire logic holder_enable_data_i,
   output logic bus_holder_enable_o,
   output logic chipsel_mode_o
);
   // ****************************************
   // elaboration check
   // ****************************************
   if (NUM_PINS != PPCS_NUM_PINS) begin : g_bad_pins
      $error("ppcs_pin_mux serves exactly three pins");
   end

   logic chipsel_mode;
   logic rst_q;
   logic off_mode;
   logic float_all;

   // ****************************************
   // strap capture
   // ****************************************
   // strap is sampled every reset cycle; last sample before release sticks
   always_ff @(posedge clk_i) begin
      rst_q <= rst_i;
      if (rst_i) begin
         chipsel_mode <= (function_strap_input_i == PPCS_STRAP_CHIPSEL);
      end
   end // held outside reset

   assign off_mode = (test_reset_i == PPCS_OFF_TRST) && (emulation_pin_zero_i == PPCS_OFF_EMULATION_PIN_ZERO)
                     && (emulation_one_off_input_i == PPCS_OFF_EMU1);
   assign float_all = off_mode || hold_i;

   // ****************************************
   // pin drivers
   // ****************************************
   // index i is memory space i and gpio number base+i
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            pin_oe_o[i] <= 1'h0;
            pin_o[i] <= PPCS_CS_INACTIVE;
            gpio_in_o[i] <= 1'h0;
         end else begin
            gpio_in_o[i] <= pin_i[i];
            // hold and off win over both functions: another owner has the pads
            if (float_all) begin
               pin_oe_o[i] <= 1'h0;
               pin_o[i] <= PPCS_CS_INACTIVE;
            end else if (chipsel_mode) begin
               pin_oe_o[i] <= 1'h1;
               // first cycle out of reset shows idle high whatever the interface drives
               pin_o[i] <= rst_q ? PPCS_CS_INACTIVE : mem_space_select_i[i];
            end else begin
               pin_oe_o[i] <= gpio_dir_out_i[i];
               pin_o[i] <= gpio_out_i[i];
            end
         end
      end

      property p_space_map;
         @(posedge clk_i) disable iff (rst_i)
            (chipsel_mode && !float_all && !rst_q) |=>
            (rst_i || (pin_oe_o[i] && pin_o[i] == $past(mem_space_select_i[i])));
      endproperty
      a_space_map: assert property (p_space_map) else $error("select on wrong pin");
   end

   // ****************************************
   // memory clock, holder and mode output
   // ****************************************
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         memory_clock_outputs_o <= 1'h0;
         memory_clock_outputs_oe_o <= 1'h1;
      end else begin
         memory_clock_outputs_o <= memclk_i;
         memory_clock_outputs_oe_o <= !(hold_i &&
            memclk_hold_tristate_bit_i == PPCS_HOLD_TRISTATE_FLOAT);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_holder_enable_o <= PPCS_HOLDER_RESET;
      end else if (holder_enable_wr_i) begin
         bus_holder_enable_o <= holder_enable_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chipsel_mode_o <= 1'h0;
      end else begin
         chipsel_mode_o <= chipsel_mode;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_mode_stable;
      @(posedge clk_i) disable iff (rst_i) !$fell(rst_i) |-> $stable(chipsel_mode);
   endproperty
   a_mode_stable: assert property (p_mode_stable) else $error("mode changed");

   property p_reset_float;
      @(posedge clk_i) rst_i |=> pin_oe_o == '0;
   endproperty
   a_reset_float: assert property (p_reset_float) else $error("pin driven in reset");

   property p_hold_float;
      @(posedge clk_i) disable iff (rst_i) hold_i |=> (rst_i || pin_oe_o == '0);
   endproperty
   a_hold_float: assert property (p_hold_float) else $error("pin driven in hold");

   property p_off_float;
      @(posedge clk_i) disable iff (rst_i) off_mode |=> (rst_i || pin_oe_o == '0);
   endproperty
   a_off_float: assert property (p_off_float) else $error("pin driven in off");

   property p_cs_idle;
      @(posedge clk_i) disable iff (rst_i)
         ($fell(rst_i) && chipsel_mode && !float_all) |=> (pin_o == '1 && pin_oe_o == '1);
   endproperty
   a_cs_idle: assert property (p_cs_idle) else $error("chip select not idle high");

   property p_gpio_input;
      @(posedge clk_i) disable iff (rst_i)
         ($fell(rst_i) && !chipsel_mode && gpio_dir_out_i == '0) |=> pin_oe_o == '0;
   endproperty
   a_gpio_input: assert property (p_gpio_input) else $error("gpio not input");

   property p_gpio_dir;
      @(posedge clk_i) disable iff (rst_i)
         (!chipsel_mode && !float_all) |=> (rst_i || pin_oe_o == $past(gpio_dir_out_i));
   endproperty
   a_gpio_dir: assert property (p_gpio_dir) else $error("gpio direction wrong");

   property p_clk_float;
      @(posedge clk_i) disable iff (rst_i)
         (hold_i && memclk_hold_tristate_bit_i) |=> (rst_i || !memory_clock_outputs_oe_o);
   endproperty
   a_clk_float: assert property (p_clk_float) else $error("memory clock driven");

   property p_holder_default;
      @(posedge clk_i) rst_i |=> bus_holder_enable_o;
   endproperty
   a_holder_default: assert property (p_holder_default) else $error("holder off");

   property p_holder_write;
      @(posedge clk_i) disable iff (rst_i)
         holder_enable_wr_i |=> (rst_i || bus_holder_enable_o == $past(holder_enable_data_i));
   endproperty
   a_holder_write: assert property (p_holder_write) else $error("holder write lost");

   property p_clk_run;
      @(posedge clk_i) disable iff (rst_i)
         (hold_i && memclk_hold_tristate_bit_i != PPCS_HOLD_TRISTATE_FLOAT) |=>
         (rst_i || memory_clock_outputs_oe_o);
   endproperty
   a_clk_run: assert property (p_clk_run) else $error("memory clock stopped");

   property p_clk_follow;
      @(posedge clk_i) disable iff (rst_i)
         !rst_i |=> (rst_i || memory_clock_outputs_o == $past(memclk_i));
   endproperty
   a_clk_follow: assert property (p_clk_follow) else $error("memory clock not passed");

   property p_gpio_out;
      @(posedge clk_i) disable iff (rst_i)
         (!chipsel_mode && !float_all) |=> (rst_i || pin_o == $past(gpio_out_i));
   endproperty
   a_gpio_out: assert property (p_gpio_out) else $error("gpio output wrong");

   property p_strap_mode;
      @(posedge clk_i) disable iff (rst_i)
         $fell(rst_i) |=>
         (rst_i || chipsel_mode_o == ($past(function_strap_input_i, 2) == PPCS_STRAP_CHIPSEL));
   endproperty
   a_strap_mode: assert property (p_strap_mode) else $error("mode not from strap");

   property p_strap_ignored;
      @(posedge clk_i) disable iff (rst_i)
         !$fell(rst_i) |=> (rst_i || $stable(chipsel_mode_o));
   endproperty
   a_strap_ignored: assert property (p_strap_ignored) else $error("mode followed strap");

   property p_float_idle;
      @(posedge clk_i) disable iff (rst_i)
         float_all |=> (rst_i || pin_o == '1);
   endproperty
   a_float_idle: assert property (p_float_idle) else $error("floating pin not idle");
endmodule : ppcs_pin_mux
`default_nettype wire

// ---- design/ppcs_pkg.sv ----
// package: constants for the parallel port chip-select pin mux
package ppcs_pkg;
   // ****************************************
   // pin layout
   // ****************************************
   localparam int PPCS_NUM_PINS = 3;
   localparam int PPCS_PIN_SPACE_ZERO = 0;
   localparam int PPCS_PIN_SPACE_ONE = 1;
   localparam int PPCS_PIN_SPACE_TWO = 2;
   localparam int PPCS_GPIO_NUM_BASE = 24;
   // ****************************************
   // reset values, strap, hold and off encodings
   // ****************************************
   localparam logic PPCS_STRAP_GPIO = 1'h0;
   localparam logic PPCS_STRAP_CHIPSEL = 1'h1;
   localparam logic PPCS_CS_INACTIVE = 1'h1;
   localparam logic PPCS_HOLDER_RESET = 1'h1;
   localparam logic PPCS_HOLD_TRISTATE_FLOAT = 1'h1;
   localparam logic PPCS_OFF_TRST = 1'h0;
   localparam logic PPCS_OFF_EMULATION_PIN_ZERO = 1'h1;
   localparam logic PPCS_OFF_EMU1 = 1'h0;
endpackage : ppcs_pkg

// ---- sim/ppcs_ext_mem.sv ----
// partner: external memory devices seen at the three pads
`timescale 1ns/1ps
`default_nettype none
module ppcs_ext_mem (
   input wire logic [2:0] cs_i,
   input wire logic [2:0] cs_oe_i,
   input wire logic [2:0] drv_i,
   input wire logic drv_en_i,
   output logic [2:0] pad_o
);
   // a released pad shows drv_i while drv_en_i is high and its inverse otherwise, never a stale copy of the drive
   assign pad_o = (cs_oe_i & cs_i) | (~cs_oe_i & (drv_en_i ? drv_i : ~drv_i));
endmodule : ppcs_ext_mem
`default_nettype wire

// ---- sim/test_parallel_port_chip_select_pin_mux.sv ----
// testbench: strap, reset, hold, off and gpio behaviour of the pin mux
`timescale 1ns/1ps
`default_nettype none
module test_parallel_port_chip_select_pin_mux;
   logic clk = 0, rst = 1, strap = 1, hold = 0, mclk = 0, mtri = 0, trst = 1, emulation_pin_zero = 0;
   logic emu1 = 1, hwr = 0, hdat = 0, drv_en = 0, hen, mode, mco, mcoe;
   logic [2:0] pad, pin_o, oe, gin, dir = 3'h0, gout = 3'h0, sel = 3'h7, drv = 3'h0;
   int fail_count = 0, n_compared = 0;
   initial forever #25 clk = ~clk;
   always @(negedge clk) mclk <= ~mclk;
   ppcs_pin_mux ppcs_pin_mux_inst (.clk_i(clk), .rst_i(rst), .function_strap_input_i(strap),
      .pin_i(pad), .pin_o(pin_o), .pin_oe_o(oe), .gpio_dir_out_i(dir), .gpio_out_i(gout),
      .gpio_in_o(gin), .mem_space_select_i(sel), .hold_i(hold), .memclk_i(mclk),
      .memclk_hold_tristate_bit_i(mtri), .memory_clock_outputs_o(mco),
      .memory_clock_outputs_oe_o(mcoe), .test_reset_i(trst), .emulation_pin_zero_i(emulation_pin_zero),
      .emulation_one_off_input_i(emu1), .holder_enable_wr_i(hwr),
      .holder_enable_data_i(hdat), .bus_holder_enable_o(hen), .chipsel_mode_o(mode));
   ppcs_ext_mem ppcs_ext_mem_inst (.cs_i(pin_o), .cs_oe_i(oe), .drv_i(drv),
      .drv_en_i(drv_en), .pad_o(pad));
   task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic do_reset(input logic s);
      rst = 1;
      strap = s;
      cyc(5);
      chk(oe, 3'h0);
      chk({2'h0, mode}, 3'h0);
      chk({2'h0, hen}, 3'h1);
      rst = 0;
      cyc(1);
   endtask : do_reset
   initial begin
      #(200 * 50);
      fail_count++;
      conclude();
   end
   initial begin
      do_reset(1'h1);
      chk(oe, 3'h7);
      chk(pin_o, 3'h7);
      chk({2'h0, mode}, 3'h1);
      strap = 0;
      // one space at a time, so a swapped pin shows up
      for (int i = 0; i < 3; i++) begin
         sel = 3'(~(3'h1 << i));
         cyc(2);
         chk(pin_o, 3'(~(3'h1 << i)));
      end
      chk({2'h0, mode}, 3'h1);
      hold = 1;
      mtri = 1;
      cyc(2);
      chk(oe, 3'h0);
      chk({2'h0, mcoe}, 3'h0);
      mtri = 0;
      cyc(2);
      chk({2'h0, mcoe}, 3'h1);
      chk({2'h0, mco}, {2'h0, mclk});
      cyc(1);
      chk({2'h0, mco}, {2'h0, mclk});
      hold = 0;
      cyc(2);
      chk(oe, 3'h7);
      trst = 0;
      emulation_pin_zero = 1;
      emu1 = 0;
      cyc(2);
      chk(oe, 3'h0);
      emu1 = 1;
      cyc(2);
      chk(oe, 3'h7);
      hwr = 1;
      cyc(1);
      chk({2'h0, hen}, 3'h0);
      hdat = 1;
      cyc(1);
      chk({2'h0, hen}, 3'h1);
      hdat = 0;
      cyc(1);
      hwr = 0;
      cyc(1);
      chk({2'h0, hen}, 3'h0);
      do_reset(1'h0);
      chk(oe, 3'h0);
      chk({2'h0, mode}, 3'h0);
      dir = 3'h2;
      gout = 3'h2;
      drv = 3'h5;
      drv_en = 1;
      cyc(3);
      chk(oe, 3'h2);
      chk(gin, 3'h7);
      gout = 3'h0;
      cyc(3);
      chk(gin, 3'h5);
      conclude();
   end
endmodule : test_parallel_port_chip_select_pin_mux
`default_nettype wire
